// >>> hw/tss_regs.svh
// timing figures and clock rate for the transfer switch sequencer
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH
`define TSS_CLK_HZ 64'd40000000
`define TSS_WEEK_S 64'd604800
`define TSS_RUN_MIN 64'd20
`define TSS_HOLDUP_S 64'd90
`define TSS_START_DLY_S 64'd3
`define TSS_TO_STBY_S 64'd1
`define TSS_TO_UTIL_S 64'd300
`define TSS_COOL_S 64'd300
`endif

// >>> hw/tss_pkg.sv
// types shared by the transfer switch sequencer
package tss_pkg;
  typedef logic [47:0] tss_cnt_t;
  // sensed inputs, all asynchronous to ref_clk
  typedef struct packed {
    logic util_lo3;       // utility below three-phase dropout
    logic util_hi3;       // utility above three-phase pickup
    logic util_lo1;       // utility below single-phase dropout
    logic util_hi1;       // utility above single-phase pickup
    logic stby_lo;        // standby below dropout
    logic stby_hi;        // standby above pickup
    logic phase_select_gnd; // strap ties phase_select_terminal to ground
    logic sel_set;        // exerciser switch held in set
    logic sel_enable;     // exerciser switch in enable
    logic sel_disable;    // exerciser switch in disable
  } tss_pins_t;
  // driven contacts and lamps
  typedef struct packed {
    logic start_contact;  // closed across start_contact_terminals
    logic engine_start_lamp;
    logic normal_available_lamp;
    logic standby_ok_lamp;
    logic utility_side_relay;
    logic standby_side_relay;
    logic utility_relay_lamp;
    logic standby_relay_lamp;
  } tss_out_t;
  typedef enum logic [2:0] {
    S_NORMAL   = 3'b000,
    S_START_DLY = 3'b001,
    S_WAIT_STBY = 3'b010,
    S_ON_STBY  = 3'b011,
    S_COOLDOWN = 3'b100,
    S_EXERCISE = 3'b101
  } tss_state_t;
endpackage

// >>> hw/tss_sequencer.sv
// transfer switch sequencer: source judging, transfer delays and weekly exerciser
`timescale 1ns/1ps
`include "tss_regs.svh"
module tss_sequencer #(
  parameter tss_pkg::tss_cnt_t START_DLY_CYC = 48'(`TSS_START_DLY_S * `TSS_CLK_HZ),
  parameter tss_pkg::tss_cnt_t TO_STBY_CYC = 48'(`TSS_TO_STBY_S * `TSS_CLK_HZ),
  parameter tss_pkg::tss_cnt_t TO_UTIL_CYC = 48'(`TSS_TO_UTIL_S * `TSS_CLK_HZ),
  parameter tss_pkg::tss_cnt_t COOL_CYC = 48'(`TSS_COOL_S * `TSS_CLK_HZ),
  parameter tss_pkg::tss_cnt_t RUN_CYC = 48'(`TSS_RUN_MIN * 64'd60 * `TSS_CLK_HZ),
  parameter tss_pkg::tss_cnt_t WEEK_CYC = 48'(`TSS_WEEK_S * `TSS_CLK_HZ),
  parameter tss_pkg::tss_cnt_t HOLDUP_CYC = 48'(`TSS_HOLDUP_S * `TSS_CLK_HZ)
) (
  // clock and power-up reset
  input wire logic ref_clk,
  input wire logic srst,
  // sensing and switch pins
  input wire tss_pkg::tss_pins_t pins,
  // contacts, relays and lamps
  output tss_pkg::tss_out_t outs
);

  // ****************************************
  // input synchronisers
  // ****************************************
  tss_pkg::tss_pins_t pin_meta;
  tss_pkg::tss_pins_t pin_s;
  logic set_prev;

  // two flops on every pin before use
  always_ff @(posedge ref_clk) begin
    pin_meta <= pins;
    pin_s <= pin_meta;
    set_prev <= srst ? 1'b0 : pin_s.sel_set;
  end

  // ****************************************
  // source judging
  // ****************************************
  logic util_ok;
  logic stby_ok;
  wire util_lo_sel = pin_s.phase_select_gnd ? pin_s.util_lo1 : pin_s.util_lo3;
  wire util_hi_sel = pin_s.phase_select_gnd ? pin_s.util_hi1 : pin_s.util_hi3;
  wire next_util_ok = util_lo_sel ? 1'b0 : (util_hi_sel ? 1'b1 : util_ok);
  wire next_stby_ok = pin_s.stby_lo ? 1'b0 : (pin_s.stby_hi ? 1'b1 : stby_ok);

  // hysteresis flags
  always_ff @(posedge ref_clk) begin
    util_ok <= srst ? 1'b0 : next_util_ok;
    stby_ok <= srst ? 1'b0 : next_stby_ok;
  end

  // ****************************************
  // exerciser week timer and outage hold-up
  // ****************************************
  tss_pkg::tss_cnt_t week_cnt;
  tss_pkg::tss_cnt_t outage_cnt;
  logic set_lost;
  wire any_src = util_ok | stby_ok;
  wire set_rel = set_prev & ~pin_s.sel_set;
  wire week_wrap = (week_cnt == WEEK_CYC - 48'h0000_0000_0001);
  wire outage_full = (outage_cnt >= HOLDUP_CYC);
  wire reseed = set_lost & any_src;
  wire weekly_go = week_wrap & pin_s.sel_enable & ~pin_s.sel_disable & ~set_lost;
  wire exer_go = set_rel | weekly_go;

  // week timer keeps running in every selector position
  always_ff @(posedge ref_clk) begin
    if (srst | set_rel | reseed | week_wrap) begin
      week_cnt <= '0;
    end else begin
      week_cnt <= week_cnt + 48'h0000_0000_0001;
    end
  end

  // outage counter; set point lost only past the hold-up time
  always_ff @(posedge ref_clk) begin
    if (srst | any_src) begin
      outage_cnt <= '0;
    end else if (!outage_full) begin
      outage_cnt <= outage_cnt + 48'h0000_0000_0001;
    end
    if (srst | reseed) begin
      set_lost <= 1'b0;
    end else if (outage_full) begin
      set_lost <= 1'b1;
    end
  end

  // ****************************************
  // sequence state machine
  // ****************************************
  tss_pkg::tss_state_t state;
  tss_pkg::tss_state_t next_state;
  tss_pkg::tss_cnt_t tmr;
  tss_pkg::tss_cnt_t tmr_lim;
  logic tmr_done;
  logic tmr_hold;

  // delay length for the current state
  assign tmr_lim = (state == tss_pkg::S_START_DLY) ? START_DLY_CYC :
                   (state == tss_pkg::S_WAIT_STBY) ? TO_STBY_CYC :
                   (state == tss_pkg::S_ON_STBY) ? TO_UTIL_CYC :
                   (state == tss_pkg::S_COOLDOWN) ? COOL_CYC : RUN_CYC;
  assign tmr_done = (tmr >= tmr_lim - 48'h0000_0000_0001);
  assign tmr_hold = (state == tss_pkg::S_NORMAL) | (next_state != state) |
                    ((state == tss_pkg::S_WAIT_STBY) & ~stby_ok) |
                    ((state == tss_pkg::S_ON_STBY) & ~util_ok);

  // next state; automatic sequence checked before the exerciser
  always_comb begin
    next_state = state;
    unique case (state)
      tss_pkg::S_NORMAL: begin
        if (!util_ok) begin
          next_state = tss_pkg::S_START_DLY;
        end else if (exer_go) begin
          next_state = tss_pkg::S_EXERCISE;
        end
      end
      tss_pkg::S_START_DLY: begin
        if (util_ok) begin
          next_state = tss_pkg::S_NORMAL;
        end else if (tmr_done) begin
          next_state = tss_pkg::S_WAIT_STBY;
        end
      end
      tss_pkg::S_WAIT_STBY: begin
        if (util_ok) begin
          next_state = tss_pkg::S_COOLDOWN;
        end else if (stby_ok && tmr_done) begin
          next_state = tss_pkg::S_ON_STBY;
        end
      end
      tss_pkg::S_ON_STBY: begin
        if (util_ok && tmr_done) begin
          next_state = tss_pkg::S_COOLDOWN;
        end
      end
      tss_pkg::S_COOLDOWN: begin
        if (!util_ok) begin
          next_state = tss_pkg::S_WAIT_STBY;
        end else if (tmr_done) begin
          next_state = tss_pkg::S_NORMAL;
        end
      end
      tss_pkg::S_EXERCISE: begin
        if (!util_ok) begin
          next_state = tss_pkg::S_WAIT_STBY;
        end else if (tmr_done) begin
          next_state = tss_pkg::S_NORMAL;
        end
      end
      default: begin
        next_state = tss_pkg::S_COOLDOWN;
      end
    endcase
  end

  // state and delay timer; power-up enters cooldown with engine running
  always_ff @(posedge ref_clk) begin
    state <= srst ? tss_pkg::S_COOLDOWN : next_state;
    tmr <= (srst | tmr_hold) ? '0 : tmr + 48'h0000_0000_0001;
  end

  // ****************************************
  // contact, relay and lamp drive
  // ****************************************
  wire next_run = (next_state != tss_pkg::S_NORMAL) & (next_state != tss_pkg::S_START_DLY);
  wire next_on_stby = (next_state == tss_pkg::S_ON_STBY);
  wire next_util_rly = next_util_ok & ~next_on_stby & (next_state != tss_pkg::S_WAIT_STBY);
  tss_pkg::tss_out_t next_outs;
  assign next_outs = '{start_contact: next_run, engine_start_lamp: ~next_run,
                       normal_available_lamp: next_util_ok, standby_ok_lamp: next_stby_ok & next_run,
                       utility_side_relay: next_util_rly, standby_side_relay: next_on_stby,
                       utility_relay_lamp: next_util_rly, standby_relay_lamp: next_on_stby};

  // outputs straight from flops; reset holds start contact closed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      outs <= '{start_contact: 1'b1, default: 1'b0};
    end else begin
      outs <= next_outs;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_drop_fails: assert property (@(posedge ref_clk) disable iff (srst) util_lo_sel |=> !util_ok)
    else $error("utility not failed after dropout");
  a_hyst_holds: assert property (@(posedge ref_clk) disable iff (srst)
    (util_ok && !util_lo_sel) |=> util_ok)
    else $error("utility dropped without dropout");
  a_lamp_util: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(util_ok) |-> outs.normal_available_lamp)
    else $error("normal lamp not following utility");
  a_strap_sel: assert property (@(posedge ref_clk) disable iff (srst)
    (pin_s.phase_select_gnd && pin_s.util_lo1) |=> !util_ok)
    else $error("strap did not pick single-phase thresholds");
  a_fail_seq: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_NORMAL && !util_ok) |=>
    (state == tss_pkg::S_START_DLY && !outs.utility_side_relay && !outs.normal_available_lamp))
    else $error("failure did not start start delay");
  a_abort_start: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_START_DLY && util_ok) |=> (state == tss_pkg::S_NORMAL && !outs.start_contact))
    else $error("start not cancelled on utility return");
  a_start_close: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_START_DLY && tmr_done && !util_ok) |=>
    (outs.start_contact && !outs.engine_start_lamp))
    else $error("start contact not closed after start delay");
  a_xfer_stby: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_WAIT_STBY && stby_ok && tmr_done && !util_ok) |=>
    (outs.standby_side_relay && outs.standby_relay_lamp))
    else $error("no transfer after to-standby delay");
  a_retransfer: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_ON_STBY && util_ok && tmr_done) |=>
    (outs.utility_side_relay && !outs.standby_side_relay && state == tss_pkg::S_COOLDOWN))
    else $error("no retransfer after to-utility delay");
  a_cool_stop: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_COOLDOWN && tmr_done && util_ok) |=> (!outs.start_contact && outs.engine_start_lamp))
    else $error("engine not stopped after cooldown");
  a_exer_noxfer: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_EXERCISE) |-> (outs.start_contact && !outs.standby_side_relay))
    else $error("exercise run transferred load");
  a_set_restart: assert property (@(posedge ref_clk) disable iff (srst)
    (set_rel && state == tss_pkg::S_NORMAL && util_ok) |=> (week_cnt == '0 && state == tss_pkg::S_EXERCISE))
    else $error("set release did not restart week and run");
  a_disable_blk: assert property (@(posedge ref_clk) disable iff (srst)
    (pin_s.sel_disable && !set_rel && state == tss_pkg::S_NORMAL) |=> state != tss_pkg::S_EXERCISE)
    else $error("exercise started while disabled");
  a_powerup_run: assert property (@(posedge ref_clk) $fell(srst) |-> (outs.start_contact && !outs.engine_start_lamp))
    else $error("start contact open after power-up");

  // ****************************************
  // checks on source judging, delays, exerciser and hold-up
  // ****************************************
  a_util_pickup: assert property (@(posedge ref_clk) disable iff (srst)
    (util_hi_sel && !util_lo_sel) |=> util_ok)
    else $error("utility not accepted after pickup");
  a_strap_ignore: assert property (@(posedge ref_clk) disable iff (srst)
    (pin_s.phase_select_gnd && !pin_s.util_lo1 && util_ok) |=> util_ok)
    else $error("three-phase level acted with strap fitted");
  a_start_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_START_DLY) |-> !outs.start_contact)
    else $error("start requested during start delay");
  a_stby_drop: assert property (@(posedge ref_clk) disable iff (srst)
    pin_s.stby_lo |=> (!stby_ok && !outs.standby_ok_lamp))
    else $error("standby lamp lit below dropout");
  a_stby_pick: assert property (@(posedge ref_clk) disable iff (srst)
    (pin_s.stby_hi && !pin_s.stby_lo) |=> stby_ok)
    else $error("standby not accepted after pickup");
  a_wait_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_WAIT_STBY && !stby_ok) |=> (!outs.standby_side_relay && tmr == '0))
    else $error("to-standby delay ran without standby");
  a_util_rst: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_ON_STBY && !util_ok) |=> (state == tss_pkg::S_ON_STBY && tmr == '0 && !outs.utility_side_relay))
    else $error("to-utility delay not reset on failure");
  a_cool_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_COOLDOWN) |-> outs.start_contact)
    else $error("start contact open during cooldown");
  a_exer_fail: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_EXERCISE && !util_ok) |=> (state == tss_pkg::S_WAIT_STBY && outs.start_contact))
    else $error("failure did not override exercise run");
  a_run_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (state == tss_pkg::S_EXERCISE && util_ok && !tmr_done) |=> state == tss_pkg::S_EXERCISE)
    else $error("exercise run ended early");
  a_weekly_run: assert property (@(posedge ref_clk) disable iff (srst)
    (week_wrap && pin_s.sel_enable && !pin_s.sel_disable && !set_lost &&
    state == tss_pkg::S_NORMAL && util_ok) |=> state == tss_pkg::S_EXERCISE)
    else $error("weekly run not started");
  a_week_count: assert property (@(posedge ref_clk) disable iff (srst)
    (!set_rel && !reseed && !week_wrap) |=> (week_cnt == $past(week_cnt) + 48'h0000_0000_0001))
    else $error("week timer stopped counting");
  a_holdup_keep: assert property (@(posedge ref_clk) disable iff (srst)
    (!set_lost && !outage_full) |=> !set_lost)
    else $error("set point lost inside hold-up time");
  a_lost_after: assert property (@(posedge ref_clk) disable iff (srst)
    (!any_src && outage_full) |=> set_lost)
    else $error("set point kept past hold-up time");
  a_reseed_week: assert property (@(posedge ref_clk) disable iff (srst)
    (set_lost && any_src) |=> (week_cnt == '0 && !set_lost))
    else $error("set point not re-established at source return");

endmodule // tss_sequencer

// >>> sim/tss_genset_model.sv
// standby generator set and transfer contactor model for the sequencer bench
`timescale 1ns/1ps
module tss_genset_model #(
  parameter int GEN_UP = 6,
  parameter int GEN_DN = 3
) (
  // clock
  input wire logic ref_clk,
  // contacts from the sequencer, fault control from the bench
  input wire tss_pkg::tss_out_t outs,
  input wire logic dead,
  // standby voltage levels and contactor position
  output logic stby_lo,
  output logic stby_hi,
  output logic on_stby
);
  int run_cnt = 0;
  logic pos = 1'b0;
  // engine spins up while the start contact is closed and coasts down after it opens
  always @(posedge ref_clk) begin
    if (dead) begin
      run_cnt <= 0;
    end else if (outs.start_contact) begin
      run_cnt <= (run_cnt < GEN_UP + GEN_DN) ? run_cnt + 1 : run_cnt;
    end else if (run_cnt > 0) begin
      run_cnt <= run_cnt - 1;
    end
  end
  // solenoid latches the contactor where the last energized relay sent it
  always @(posedge ref_clk) begin
    if (outs.standby_side_relay) begin
      pos <= 1'b1;
    end else if (outs.utility_side_relay) begin
      pos <= 1'b0;
    end
  end
  assign stby_hi = (run_cnt >= GEN_UP);
  assign stby_lo = ~stby_hi;
  assign on_stby = pos;
endmodule // tss_genset_model

// >>> sim/transfer_switch_sequencer_tb_top.sv
// self-checking bench for the transfer switch sequencer
`timescale 1ns/1ps
module transfer_switch_sequencer_tb_top;
  // one row: pins to apply and the outputs they lead to within a cycle window
  typedef struct {
    logic [3:0] util;
    logic [2:0] sel;
    logic strap;
    logic dead;
    logic hold;
    int lo;
    int hi;
    logic [7:0] exp;
  } tss_row_t;
  localparam logic [3:0] UG = 4'h5; // both phase sets above pickup
  localparam logic [3:0] UF = 4'ha; // both phase sets below dropout
  localparam logic [2:0] SD = 3'h1; // disable position
  localparam logic [2:0] SE = 3'h2; // enable position
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] util = UG;
  logic [2:0] sel = SD;
  logic strap = 1'b0;
  logic dead = 1'b0;
  logic stby_lo;
  logic stby_hi;
  logic on_stby;
  tss_pkg::tss_pins_t pins;
  tss_pkg::tss_out_t outs;
  tss_row_t rows[$];
  int num_errors = 0;
  int check_count = 0;
  int seen;
  assign pins = {util, stby_lo, stby_hi, strap, sel};
  // delays cut short so every sequence fits in the run
  localparam tss_pkg::tss_cnt_t T_START = 48'h0000_0000_0008;
  localparam tss_pkg::tss_cnt_t T_STBY = 48'h0000_0000_000a;
  localparam tss_pkg::tss_cnt_t T_UTIL = 48'h0000_0000_000c;
  localparam tss_pkg::tss_cnt_t T_COOL = 48'h0000_0000_000e;
  localparam tss_pkg::tss_cnt_t T_RUN = 48'h0000_0000_001e;
  localparam tss_pkg::tss_cnt_t T_WEEK = 48'h0000_0000_0190;
  localparam tss_pkg::tss_cnt_t T_HOLD = 48'h0000_0000_0032;
  tss_sequencer #(
    .START_DLY_CYC(T_START), .TO_STBY_CYC(T_STBY), .TO_UTIL_CYC(T_UTIL), .COOL_CYC(T_COOL),
    .RUN_CYC(T_RUN), .WEEK_CYC(T_WEEK), .HOLDUP_CYC(T_HOLD)
  ) u_tss_sequencer (.ref_clk(ref_clk), .srst(srst), .pins(pins), .outs(outs));
  tss_genset_model u_tss_genset_model (.ref_clk(ref_clk), .outs(outs), .dead(dead), .stby_lo(stby_lo),
    .stby_hi(stby_hi), .on_stby(on_stby));
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // compare, verdict and row helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic add(input logic [3:0] u, input logic [2:0] s, input logic st, input logic d, input logic h,
                     input int lo, input int hi, input logic [7:0] e);
    rows.push_back('{u, s, st, d, h, lo, hi, e});
  endtask
  // hold rows check every cycle, others must reach the outputs inside the window
  task automatic run_row(input tss_row_t r);
    @(posedge ref_clk);
    util <= r.util;
    sel <= r.sel;
    strap <= r.strap;
    dead <= r.dead;
    seen = 0;
    for (int n = 1; n <= r.hi; n++) begin
      @(posedge ref_clk);
      #1;
      if (r.hold) begin
        check(outs, r.exp, "held outputs");
      end else if (outs === r.exp) begin
        seen = n;
        break;
      end
    end
    if (!r.hold) begin
      check(seen >= r.lo && seen <= r.hi, 1, "outputs outside window");
      if (seen == 0) stop_test();
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    check(outs, 8'h80, "reset outputs");
    @(posedge ref_clk);
    srst <= 1'b0;
    add(UG, SD, 0, 0, 0, 12, 24, 8'h6a);
    add(UF, SD, 0, 0, 0, 3, 5, 8'h40);
    add(4'h0, SD, 0, 0, 1, 0, 5, 8'h40);
    add(UF, SD, 0, 0, 0, 1, 8, 8'h80);
    add(UF, SD, 0, 0, 0, 6, 12, 8'h90);
    add(UF, SD, 0, 0, 0, 8, 13, 8'h95);
    add(UG, SD, 0, 0, 0, 3, 5, 8'hb5);
    add(UF, SD, 0, 0, 0, 3, 5, 8'h95);
    add(UG, SD, 0, 0, 0, 3, 5, 8'hb5);
    add(UG, SD, 0, 0, 0, 9, 14, 8'hba);
    add(UG, SD, 0, 0, 0, 12, 16, 8'h6a);
    add(UF, SD, 0, 0, 0, 3, 5, 8'h40);
    add(UG, SD, 0, 0, 0, 3, 5, 8'h6a);
    add(UG, SD, 0, 0, 1, 0, 20, 8'h6a);
    add(4'h0, SD, 0, 0, 1, 0, 8, 8'h6a);
    add(4'h9, SD, 1, 0, 1, 0, 10, 8'h6a);
    add(4'h6, SD, 1, 0, 0, 3, 5, 8'h40);
    add(UG, SD, 1, 0, 0, 3, 5, 8'h6a);
    add(UG, 3'h5, 0, 0, 1, 0, 4, 8'h6a);
    add(UG, SD, 0, 0, 0, 3, 6, 8'haa);
    add(UG, SD, 0, 0, 0, 7, 13, 8'hba);
    add(UG, SE, 0, 0, 0, 14, 26, 8'h6a);
    add(UG, SE, 0, 0, 1, 0, 340, 8'h6a);
    add(UG, SE, 0, 0, 0, 28, 52, 8'hba);
    add(UF, SE, 0, 0, 0, 3, 5, 8'h90);
    add(UF, SE, 0, 0, 0, 5, 12, 8'h95);
    add(UG, SD, 0, 0, 0, 24, 34, 8'h6a);
    add(UG, SD, 0, 0, 1, 0, 420, 8'h6a);
    add(UF, SD, 0, 0, 0, 3, 5, 8'h40);
    add(UF, SD, 0, 1, 0, 5, 10, 8'h80);
    add(UF, SD, 0, 1, 1, 0, 60, 8'h80);
    add(UG, SE, 0, 1, 0, 3, 5, 8'haa);
    add(UG, SE, 0, 0, 0, 11, 18, 8'h6a);
    add(UG, SE, 0, 0, 1, 0, 360, 8'h6a);
    add(UG, SE, 0, 0, 0, 20, 34, 8'haa);
    foreach (rows[i]) run_row(rows[i]);
    // second power-up in mid exercise run
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(outs, 8'h80, "reset in mid run");
    @(posedge ref_clk);
    srst <= 1'b0;
    run_row('{UG, SD, 0, 0, 0, 12, 24, 8'h6a});
    check({31'h0000_0000, on_stby}, 0, "contactor position");
    stop_test();
  end
endmodule // transfer_switch_sequencer_tb_top
